//--- hw/cabe_pkg.sv
// shared constants and types for the execution unit of the 8-bit core
// assumes a decode stage that hands over operands already read from the register file
package cabe_pkg;

  // i/o addresses of the registers held in this block
  localparam logic [5:0] CABE_SP_LO_ADDR = 6'h3D;
  localparam logic [5:0] CABE_SP_HI_ADDR = 6'h3E;
  localparam logic [5:0] CABE_FLAGS_ADDR = 6'h3F;
  // highest address reachable by the single-bit i/o set and clear operations
  localparam logic [5:0] CABE_IO_BIT_MAX = 6'h1F;

  // values after reset
  localparam logic [7:0] CABE_FLAGS_RST = 8'h00;
  localparam logic [10:0] CABE_SP_RST = 11'h000;

  // status flag positions
  localparam int CABE_FLG_C = 0;
  localparam int CABE_FLG_Z = 1;
  localparam int CABE_FLG_N = 2;
  localparam int CABE_FLG_V = 3;
  localparam int CABE_FLG_S = 4;
  localparam int CABE_FLG_H = 5;
  localparam int CABE_FLG_T = 6;
  localparam int CABE_FLG_I = 7;

  // arithmetic constants
  localparam logic [7:0] CABE_ALL_ONES = 8'hFF;
  localparam logic [7:0] CABE_ALL_ZERO = 8'h00;
  localparam logic [7:0] CABE_SGN_MAX = 8'h7F;
  localparam logic [7:0] CABE_SGN_MIN = 8'h80;
  localparam logic [10:0] CABE_SP_STEP = 11'h002;

  // cycle counts
  localparam logic [1:0] CABE_CYC_1 = 2'h1;
  localparam logic [1:0] CABE_CYC_2 = 2'h2;
  localparam logic [1:0] CABE_CYC_3 = 2'h3;

  localparam int CABE_PC_W = 12;

  typedef enum logic [4:0] {
    CABE_OP_NOP = 5'b00000,
    CABE_OP_ADD = 5'b00001,
    CABE_OP_SUB = 5'b00010,
    CABE_OP_AND = 5'b00011,
    CABE_OP_OR = 5'b00100,
    CABE_OP_XOR = 5'b00101,
    CABE_OP_ONES = 5'b00110,
    CABE_OP_ARITH_INVERT = 5'b00111,
    CABE_OP_MASK_CLEAR = 5'b01000,
    CABE_OP_INC = 5'b01001,
    CABE_OP_DEC = 5'b01010,
    CABE_OP_ZERO_SIGN_TEST = 5'b01011,
    CABE_OP_ZERO_REGISTER = 5'b01100,
    CABE_OP_PAIR_PLUS_IMM = 5'b01101,
    CABE_OP_PAIR_MINUS_IMM = 5'b01110,
    CABE_OP_PRODUCT = 5'b01111,
    CABE_OP_COMPARE = 5'b10000,
    CABE_OP_SKIP_ON_EQUAL = 5'b10001,
    CABE_OP_SKIP_REG_BIT = 5'b10010,
    CABE_OP_SKIP_IO_BIT = 5'b10011,
    CABE_OP_JUMP_FLAG = 5'b10100,
    CABE_OP_JUMP_SIGNED = 5'b10101,
    CABE_OP_JUMP_VIA_Z = 5'b10110,
    CABE_OP_CALL_VIA_Z = 5'b10111,
    CABE_OP_IO_BIT_SET = 5'b11000,
    CABE_OP_IO_BIT_CLEAR = 5'b11001
  } cabe_op_t;

  typedef struct packed {
    cabe_op_t op;
    logic [4:0] idx_d;
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] k;
    logic [15:0] pair;
    logic [15:0] zptr;
    logic [CABE_PC_W-1:0] pc;
    logic [2:0] bsel;
    logic [5:0] io_addr;
    logic [7:0] io_val;
    logic [6:0] offs;
    logic use_imm;
    logic with_carry;
    logic want_set;
    logic next_two;
    logic sgn_d;
    logic sgn_r;
    logic frac;
  } cabe_req_t;

  typedef struct packed {
    logic rf_we;
    logic rf_pair;
    logic [4:0] rf_idx;
    logic [15:0] rf_data;
    logic pc_load;
    logic [CABE_PC_W-1:0] pc_val;
    logic push_en;
    logic [10:0] push_addr;
    logic [15:0] push_data;
    logic io_we;
    logic [5:0] io_addr;
    logic [7:0] io_wdata;
  } cabe_out_t;

  typedef struct packed {
    logic [7:0] y;
    logic c;
    logic h;
    logic v;
  } cabe_alu_t;

endpackage

//--- hw/cabe_product.sv
// two-cycle 8x8 multiplier with signed, unsigned and mixed operands
// assumes start is a one-cycle pulse; the result is valid the cycle after it
`timescale 1ns/1ps
`default_nettype none
module cabe_product
  import cabe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic sgn_a,
  input wire logic sgn_b,
  input wire logic frac,
  output logic [15:0] product,
  output logic carry
);

  logic signed [8:0] ext_a;
  logic signed [8:0] ext_b;
  logic signed [17:0] full;

  ////////////////////////////////////////////////////////////////////////
  // nine-bit extension lets one signed multiplier serve all three modes
  assign ext_a = $signed({sgn_a & a[7], a});
  assign ext_b = $signed({sgn_b & b[7], b});
  assign full = ext_a * ext_b;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      product <= 16'h0000;
      carry <= 1'b0;
    end else if (start) begin
      // carry is taken before the fractional shift drops the top bit
      carry <= full[15];
      product <= frac ? {full[14:0], 1'b0} : full[15:0];
    end
  end

endmodule
`default_nettype wire

//--- hw/cabe_exec.sv
// execution unit: arithmetic, logic, multiply, compare, skip and branch
// assumes the decode stage holds req stable while req_valid is high and not taken
`timescale 1ns/1ps
`default_nettype none
module cabe_exec
  import cabe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic req_valid,
  output logic req_ready,
  input wire cabe_req_t req,
  output logic done,
  output cabe_out_t res,
  output logic [7:0] status_flags,
  output logic [10:0] stack_ptr,
  input wire logic sw_io_we,
  input wire logic [5:0] sw_io_addr,
  input wire logic [7:0] sw_io_wdata,
  output logic [7:0] sw_io_rdata
);

  function automatic cabe_alu_t cabe_addsub(input logic [7:0] a, input logic [7:0] b,
                                            input logic ci, input logic sub);
    cabe_alu_t o;
    logic [8:0] w;
    logic [4:0] n;
    if (sub) begin
      w = {1'b0, a} - {1'b0, b} - {8'h00, ci};
      n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
      o.v = (a[7] & ~b[7] & ~w[7]) | (~a[7] & b[7] & w[7]);
    end else begin
      w = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      o.v = (a[7] & b[7] & ~w[7]) | (~a[7] & ~b[7] & w[7]);
    end
    o.y = w[7:0];
    o.c = w[8];
    o.h = n[4];
    return o;
  endfunction

  // sign flag always follows N xor V
  function automatic logic [7:0] cabe_nzv(input logic [7:0] f, input logic [7:0] y,
                                          input logic v);
    logic [7:0] o;
    o = f;
    o[CABE_FLG_N] = y[7];
    o[CABE_FLG_Z] = (y == CABE_ALL_ZERO);
    o[CABE_FLG_V] = v;
    o[CABE_FLG_S] = y[7] ^ v;
    return o;
  endfunction

  logic [7:0] flags_r;
  logic [10:0] sp_r;
  logic [1:0] cnt_r;
  cabe_out_t pend_r;
  logic [7:0] pend_flags_r;
  logic pend_prod_r;
  logic pend_call_r;
  cabe_out_t res_r;
  logic done_r;
  logic [7:0] rdata_r;

  logic accept;
  cabe_out_t nres;
  logic [7:0] nflags;
  logic [1:0] ncyc;
  logic emit_now;
  logic emit_late;
  cabe_out_t emit_res;
  logic [7:0] emit_flags;
  logic emit_call;
  logic [15:0] prod;
  logic prod_c;

  assign req_ready = (cnt_r == 2'h0);
  assign accept = req_valid & req_ready;
  assign done = done_r;
  assign res = res_r;
  assign status_flags = flags_r;
  assign stack_ptr = sp_r;
  assign sw_io_rdata = rdata_r;

  cabe_product u_product (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(accept && req.op == CABE_OP_PRODUCT),
    .a(req.d),
    .b(req.r),
    .sgn_a(req.sgn_d),
    .sgn_b(req.sgn_r),
    .frac(req.frac),
    .product(prod),
    .carry(prod_c)
  );

  ////////////////////////////////////////////////////////////////////////
  // operation decode and datapath, all evaluated in the taking cycle
  always_comb begin
    cabe_alu_t a;
    logic [7:0] b_op;
    logic [7:0] y;
    logic [16:0] w;
    logic cond;
    logic [CABE_PC_W-1:0] pc_next;
    a = '0;
    b_op = req.use_imm ? req.k : req.r;
    y = CABE_ALL_ZERO;
    w = 17'h00000;
    cond = 1'b0;
    pc_next = req.pc + {{(CABE_PC_W-1){1'b0}}, 1'b1};
    nres = '0;
    nres.rf_idx = req.idx_d;
    nflags = flags_r;
    ncyc = CABE_CYC_1;
    case (req.op)
      CABE_OP_ADD, CABE_OP_SUB, CABE_OP_COMPARE: begin
        a = cabe_addsub(req.d, b_op, req.with_carry & flags_r[CABE_FLG_C],
                        req.op != CABE_OP_ADD);
        nres.rf_we = (req.op != CABE_OP_COMPARE);
        nres.rf_data = {8'h00, a.y};
        nflags = cabe_nzv(flags_r, a.y, a.v);
        nflags[CABE_FLG_C] = a.c;
        nflags[CABE_FLG_H] = a.h;
        // borrow forms only keep Z if the earlier bytes were zero too
        if (req.op != CABE_OP_ADD && req.with_carry) begin
          nflags[CABE_FLG_Z] = flags_r[CABE_FLG_Z] & (a.y == CABE_ALL_ZERO);
        end
      end
      CABE_OP_AND, CABE_OP_OR, CABE_OP_XOR, CABE_OP_MASK_CLEAR, CABE_OP_ZERO_SIGN_TEST,
      CABE_OP_ZERO_REGISTER: begin
        case (req.op)
          CABE_OP_AND: y = req.d & b_op;
          CABE_OP_OR: y = req.d | b_op;
          CABE_OP_XOR: y = req.d ^ req.r;
          CABE_OP_MASK_CLEAR: y = req.d & (CABE_ALL_ONES - req.k);
          CABE_OP_ZERO_SIGN_TEST: y = req.d & req.d;
          default: y = req.d ^ req.d;
        endcase
        nres.rf_we = (req.op != CABE_OP_ZERO_SIGN_TEST);
        nres.rf_data = {8'h00, y};
        nflags = cabe_nzv(flags_r, y, 1'b0);
      end
      CABE_OP_INC, CABE_OP_DEC: begin
        y = (req.op == CABE_OP_INC) ? req.d + 8'h01 : req.d - 8'h01;
        nres.rf_we = 1'b1;
        nres.rf_data = {8'h00, y};
        nflags = cabe_nzv(flags_r, y,
                          req.d == ((req.op == CABE_OP_INC) ? CABE_SGN_MAX : CABE_SGN_MIN));
      end
      CABE_OP_ONES: begin
        y = CABE_ALL_ONES - req.d;
        nres.rf_we = 1'b1;
        nres.rf_data = {8'h00, y};
        nflags = cabe_nzv(flags_r, y, 1'b0);
        nflags[CABE_FLG_C] = 1'b1;
      end
      CABE_OP_ARITH_INVERT: begin
        a = cabe_addsub(CABE_ALL_ZERO, req.d, 1'b0, 1'b1);
        nres.rf_we = 1'b1;
        nres.rf_data = {8'h00, a.y};
        nflags = cabe_nzv(flags_r, a.y, a.v);
        nflags[CABE_FLG_C] = a.c;
        nflags[CABE_FLG_H] = a.h;
      end
      CABE_OP_PAIR_PLUS_IMM, CABE_OP_PAIR_MINUS_IMM: begin
        ncyc = CABE_CYC_2;
        if (req.op == CABE_OP_PAIR_PLUS_IMM) begin
          w = {1'b0, req.pair} + {11'h000, req.k[5:0]};
          nflags[CABE_FLG_V] = ~req.pair[15] & w[15];
          nflags[CABE_FLG_C] = req.pair[15] & ~w[15];
        end else begin
          w = {1'b0, req.pair} - {11'h000, req.k[5:0]};
          nflags[CABE_FLG_V] = req.pair[15] & ~w[15];
          nflags[CABE_FLG_C] = ~req.pair[15] & w[15];
        end
        nflags[CABE_FLG_N] = w[15];
        nflags[CABE_FLG_Z] = (w[15:0] == 16'h0000);
        nflags[CABE_FLG_S] = w[15] ^ nflags[CABE_FLG_V];
        nres.rf_we = 1'b1;
        nres.rf_pair = 1'b1;
        nres.rf_data = w[15:0];
      end
      CABE_OP_PRODUCT: begin
        // data and Z, C are filled in from the multiplier in the second cycle
        ncyc = CABE_CYC_2;
        nres.rf_we = 1'b1;
        nres.rf_pair = 1'b1;
        nres.rf_idx = 5'h00;
      end
      CABE_OP_SKIP_ON_EQUAL, CABE_OP_SKIP_REG_BIT, CABE_OP_SKIP_IO_BIT: begin
        case (req.op)
          CABE_OP_SKIP_ON_EQUAL: cond = (req.d == req.r);
          CABE_OP_SKIP_REG_BIT: cond = (req.r[req.bsel] == req.want_set);
          default: cond = (req.io_val[req.bsel] == req.want_set);
        endcase
        if (cond) begin
          ncyc = req.next_two ? CABE_CYC_3 : CABE_CYC_2;
          nres.pc_load = 1'b1;
          nres.pc_val = req.pc + (req.next_two ? 12'h003 : 12'h002);
        end
      end
      CABE_OP_JUMP_FLAG, CABE_OP_JUMP_SIGNED: begin
        if (req.op == CABE_OP_JUMP_SIGNED) begin
          cond = ((flags_r[CABE_FLG_N] ^ flags_r[CABE_FLG_V]) == req.want_set);
        end else begin
          cond = (flags_r[req.bsel] == req.want_set);
        end
        if (cond) begin
          ncyc = CABE_CYC_2;
          nres.pc_load = 1'b1;
          nres.pc_val = pc_next + {{(CABE_PC_W-7){req.offs[6]}}, req.offs};
        end
      end
      CABE_OP_JUMP_VIA_Z: begin
        ncyc = CABE_CYC_2;
        nres.pc_load = 1'b1;
        nres.pc_val = req.zptr[CABE_PC_W-1:0];
      end
      CABE_OP_CALL_VIA_Z: begin
        ncyc = CABE_CYC_3;
        nres.pc_load = 1'b1;
        nres.pc_val = req.zptr[CABE_PC_W-1:0];
        nres.push_en = 1'b1;
        nres.push_addr = sp_r;
        nres.push_data = {{(16-CABE_PC_W){1'b0}}, pc_next};
      end
      CABE_OP_IO_BIT_SET, CABE_OP_IO_BIT_CLEAR: begin
        ncyc = CABE_CYC_2;
        // out-of-reach addresses still take their slot but write nothing
        nres.io_we = (req.io_addr <= CABE_IO_BIT_MAX);
        nres.io_addr = req.io_addr;
        // whole byte goes back, so set flags read here get cleared by their one
        nres.io_wdata = req.io_val;
        nres.io_wdata[req.bsel] = (req.op == CABE_OP_IO_BIT_SET);
      end
      default: begin
        nres = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // completion: one-cycle work leaves at once, longer work from the pending copy
  assign emit_now = accept && (ncyc == CABE_CYC_1);
  assign emit_late = (cnt_r == 2'h1);

  always_comb begin
    emit_res = nres;
    emit_flags = nflags;
    emit_call = 1'b0;
    if (emit_late) begin
      emit_res = pend_r;
      emit_flags = pend_flags_r;
      emit_call = pend_call_r;
      if (pend_prod_r) begin
        emit_res.rf_data = prod;
        emit_flags[CABE_FLG_C] = prod_c;
        emit_flags[CABE_FLG_Z] = (prod == 16'h0000);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_r <= 2'h0;
    end else if (accept) begin
      cnt_r <= ncyc - CABE_CYC_1;
    end else if (cnt_r != 2'h0) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pend_r <= '0;
      pend_flags_r <= CABE_FLAGS_RST;
      pend_prod_r <= 1'b0;
      pend_call_r <= 1'b0;
    end else if (accept) begin
      pend_r <= nres;
      pend_flags_r <= nflags;
      pend_prod_r <= (req.op == CABE_OP_PRODUCT);
      pend_call_r <= (req.op == CABE_OP_CALL_VIA_Z);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      res_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= emit_now | emit_late;
      res_r <= (emit_now | emit_late) ? emit_res : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags and stack pointer; finishing instruction wins over software
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flags_r <= CABE_FLAGS_RST;
    end else if (emit_now | emit_late) begin
      flags_r <= emit_flags;
    end else if (sw_io_we && sw_io_addr == CABE_FLAGS_ADDR) begin
      flags_r <= sw_io_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sp_r <= CABE_SP_RST;
    end else if (emit_late && emit_call) begin
      sp_r <= sp_r - CABE_SP_STEP;
    end else if (sw_io_we && sw_io_addr == CABE_SP_LO_ADDR) begin
      sp_r[7:0] <= sw_io_wdata;
    end else if (sw_io_we && sw_io_addr == CABE_SP_HI_ADDR) begin
      // upper bits are reserved and are dropped on write
      sp_r[10:8] <= sw_io_wdata[2:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else begin
      case (sw_io_addr)
        CABE_FLAGS_ADDR: rdata_r <= flags_r;
        CABE_SP_LO_ADDR: rdata_r <= sp_r[7:0];
        CABE_SP_HI_ADDR: rdata_r <= {5'h00, sp_r[10:8]};
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_quiet_1;
    !done ##1 done;
  endsequence

  sequence s_quiet_2;
    !done ##1 !done ##1 done;
  endsequence

  a_add_one_cycle: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accept && req.op == CABE_OP_ADD && !req.use_imm && !req.with_carry) |=>
      done && res.rf_we && res.rf_data[7:0] == 8'($past(req.d) + $past(req.r)))
    else $error("add result or timing wrong");

  a_compare_no_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accept && req.op == CABE_OP_COMPARE) |=> done && !res.rf_we &&
      ($past(req.with_carry) || $past(req.use_imm) ||
      status_flags[CABE_FLG_Z] == ($past(req.d) == $past(req.r))))
    else $error("compare wrote a register or missed zero");

  a_pair_two_cycles: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accept && req.op == CABE_OP_PAIR_PLUS_IMM) |=> s_quiet_1 ##0 res.rf_pair)
    else $error("pair add not two cycles");

  a_product_place: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accept && req.op == CABE_OP_PRODUCT && !req.frac && !req.sgn_d && !req.sgn_r) |=>
      s_quiet_1 ##0 (res.rf_idx == 5'h00 && res.rf_data == $past(req.d, 2) * $past(req.r, 2)))
    else $error("unsigned product misplaced");

  a_jump_z_target: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accept && req.op == CABE_OP_JUMP_VIA_Z) |=>
      s_quiet_1 ##0 (res.pc_load && res.pc_val == $past(req.zptr[CABE_PC_W-1:0], 2)))
    else $error("indirect jump target or timing wrong");

  a_call_three_cycles: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accept && req.op == CABE_OP_CALL_VIA_Z) |=> s_quiet_2 ##0 res.push_en ##1
      stack_ptr == $past(stack_ptr, 3) - CABE_SP_STEP)
    else $error("indirect call timing or stack wrong");

  a_skip_cost: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accept && req.op == CABE_OP_SKIP_ON_EQUAL && req.d == req.r && req.next_two) |=>
      s_quiet_2 ##0 (res.pc_load && res.pc_val == $past(req.pc, 3) + 12'h003))
    else $error("two-word skip not three cycles");

  a_branch_flags_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accept && req.op == CABE_OP_JUMP_FLAG && !sw_io_we) |=> status_flags == $past(status_flags))
    else $error("branch altered flags");

  a_io_bit_reach: assert property (@(posedge clk_sys) disable iff (!rstn)
    res.io_we |-> res.io_addr <= CABE_IO_BIT_MAX)
    else $error("i/o bit write beyond reach");

  a_untaken_branch: assert property (@(posedge clk_sys) disable iff (!rstn)
    (accept && req.op == CABE_OP_JUMP_SIGNED &&
      ((status_flags[CABE_FLG_N] ^ status_flags[CABE_FLG_V]) != req.want_set)) |=>
      done && !res.pc_load)
    else $error("signed branch taken wrongly");

endmodule
`default_nettype wire

//--- test/cabe_regfile.sv
// register file model standing behind the execution unit's write port
// assumes res only counts while done is high
`timescale 1ns/1ps
`default_nettype none
module cabe_regfile
  import cabe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic done,
  input wire cabe_out_t res,
  input wire logic [4:0] rd_idx,
  output logic [7:0] rd_data
);
  logic [7:0] mem_r [32];
  // a pair arrives whole; high byte lands one index up
  always_ff @(posedge clk_sys) begin
    if (done && res.rf_we) begin
      mem_r[res.rf_idx] <= res.rf_data[7:0];
      if (res.rf_pair) begin
        mem_r[res.rf_idx + 5'h1] <= res.rf_data[15:8];
      end
    end
  end
  assign rd_data = mem_r[rd_idx];
endmodule
`default_nettype wire

//--- test/cabe_exec_bench.sv
// self-checking bench for the execution unit with a register file model
// assumes operands arrive already read, so the bench fills req directly
`timescale 1ns/1ps
`default_nettype none
module cabe_exec_bench
  import cabe_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic sw_io_we = 1'b0;
  logic [5:0] sw_io_addr = 6'h00;
  logic [7:0] sw_io_wdata = 8'h00;
  logic [4:0] rf_sel = 5'h00;
  cabe_req_t req = '0;
  cabe_req_t r;
  cabe_out_t res, got;
  logic req_ready, done;
  logic [7:0] status_flags, sw_io_rdata, rf_q;
  logic [10:0] stack_ptr;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 93190;
  int ncyc, a, b, c, e;
  int cyc[5] = '{3, 1, 2, 1, 3};
  cabe_op_t sops[5] = '{CABE_OP_SKIP_ON_EQUAL, CABE_OP_SKIP_ON_EQUAL, CABE_OP_SKIP_REG_BIT,
    CABE_OP_SKIP_IO_BIT, CABE_OP_SKIP_IO_BIT};
  cabe_op_t lops[10] = '{CABE_OP_AND, CABE_OP_MASK_CLEAR, CABE_OP_OR, CABE_OP_XOR, CABE_OP_INC,
    CABE_OP_DEC, CABE_OP_ZERO_SIGN_TEST, CABE_OP_ZERO_REGISTER, CABE_OP_ONES,
    CABE_OP_ARITH_INVERT};
  logic [7:0] bfl[6] = '{8'h01, 8'h01, 8'h0C, 8'h0C, 8'h60, 8'h08};
  logic [2:0] bsl[6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h6, 3'h3};
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  cabe_exec u_cabe_exec (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .done(done), .res(res), .status_flags(status_flags),
    .stack_ptr(stack_ptr), .sw_io_we(sw_io_we), .sw_io_addr(sw_io_addr),
    .sw_io_wdata(sw_io_wdata), .sw_io_rdata(sw_io_rdata));
  cabe_regfile u_cabe_regfile (.clk_sys(clk_sys), .done(done), .res(res), .rd_idx(rf_sel),
    .rd_data(rf_q));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input int exp);
    total_checks++;
    if (seen !== 16'(exp)) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, 16'(exp));
    end
  endtask
  // request held until taken; ready is high since the last op is done
  task automatic run(input cabe_req_t q);
    req = q;
    req_valid = 1'b1;
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    ncyc = 1;
    while (done !== 1'b1 && ncyc < 9) begin
      @(posedge clk_sys);
      #1 ncyc++;
    end
    got = res;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic sw_wr(input logic [5:0] ad, input logic [7:0] v);
    sw_io_addr = ad;
    sw_io_wdata = v;
    sw_io_we = 1'b1;
    @(posedge clk_sys);
    #1 sw_io_we = 1'b0;
  endtask
  // flags as {H, V, N, Z, C}; each term is one bit so nothing is cut off
  function automatic logic [4:0] fl(input int a, input int b, input int c, input bit sub);
    int s;
    int x;
    s = sub ? a - b : a + b + c;
    x = sub ? (a ^ b) & (a ^ s) : ~(a ^ b) & (a ^ s);
    return {sub ? (a & 15) < (b & 15) : (a & 15) + (b & 15) + c > 15, x[7], s[7],
      (s & 255) == 0, s[8]};
  endfunction
  function automatic int lres(input int i, input int a);
    case (i)
      0: return a & 8'h3C;
      1: return a & (8'hFF - 8'h3C);
      2: return a | 8'h3C;
      3: return a ^ 8'h3C;
      4: return (a + 1) & 255;
      5: return (a - 1) & 255;
      6: return a;
      7: return 0;
      8: return 8'hFF - a;
      default: return (9'h100 - a) & 8'hFF;
    endcase
  endfunction
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rstn = 1'b1;
    chk(status_flags, 0);
    chk(stack_ptr, 0);
    for (int i = 0; i < 12; i++) begin
      a = $random(seed) & 255;
      b = $random(seed) & 255;
      c = (i[1] & ~i[0]) ? status_flags[0] : 0;
      e = i[0] ? a - b : a + b + c;
      r = '0;
      r.op = i[0] ? CABE_OP_SUB : CABE_OP_ADD;
      r.idx_d = 5'(i + 2);
      r.d = 8'(a);
      r.r = 8'(b);
      r.with_carry = i[1] & ~i[0];
      run(r);
      chk({status_flags[5], status_flags[3:0]}, fl(a, b, c, i[0]));
      rf_sel = r.idx_d;
      #1 chk(rf_q, e & 255);
      chk(ncyc, 1);
    end
    $display("test add_sub done");
    for (int i = 0; i < 4; i++) begin
      a = $random(seed) & 255;
      b = i[0] ? a : $random(seed) & 255;
      r = '0;
      r.op = CABE_OP_COMPARE;
      r.d = 8'(a);
      r.r = 8'(b);
      run(r);
      chk(got.rf_we, 0);
      chk({status_flags[5], status_flags[3:0]}, fl(a, b, 0, 1));
      chk(ncyc, 1);
    end
    $display("test compare done");
    sw_wr(CABE_FLAGS_ADDR, 8'h01);
    for (int i = 0; i < 10; i++) begin
      a = $random(seed) & 255;
      e = lres(i, a);
      r = '0;
      r.op = lops[i];
      r.d = 8'(a);
      r.k = 8'h3C;
      r.r = 8'h3C;
      r.use_imm = 1'b1;
      run(r);
      chk(got.rf_data[7:0], e);
      chk(status_flags[2:1], {e[7], e == 0});
      if (i < 8) begin
        chk(status_flags[0], 1);
      end
      chk(ncyc, 1);
    end
    $display("test logic done");
    for (int i = 0; i < 3; i++) begin
      a = $random(seed) & 255;
      b = $random(seed) & 255;
      e = i[1] ? ((a ^ 128) - 128) * ((b ^ 128) - 128) : a * b;
      r = '0;
      r.op = CABE_OP_PRODUCT;
      r.d = 8'(a);
      r.r = 8'(b);
      r.frac = i[0];
      r.sgn_d = i[1];
      r.sgn_r = i[1];
      run(r);
      chk(got.rf_data, i[0] ? e << 1 : e);
      chk(status_flags[1:0], {e == 0, e[15]});
      rf_sel = 5'h1;
      #1 chk(rf_q, (i[0] ? e >> 7 : e >> 8) & 255);
      chk(ncyc, 2);
    end
    r = '0;
    r.op = CABE_OP_PAIR_PLUS_IMM;
    r.idx_d = 5'h18;
    r.pair = 16'hFFFF;
    r.k = 8'h01;
    run(r);
    chk(got.rf_data, 0);
    chk(status_flags[4:0], 3);
    chk(ncyc, 2);
    r.op = CABE_OP_PAIR_MINUS_IMM;
    r.pair = 16'h0000;
    run(r);
    chk(got.rf_data, 16'hFFFF);
    chk(status_flags[4:0], 5'h15);
    chk(ncyc, 2);
    $display("test product_pair done");
    e = status_flags;
    r = '0;
    r.op = CABE_OP_CALL_VIA_Z;
    r.zptr = 16'h0ABC;
    run(r);
    chk(got.pc_val, 12'hABC);
    chk({got.push_en, got.push_addr}, 12'h800);
    chk(stack_ptr, 11'h7FE);
    chk(ncyc, 3);
    r.op = CABE_OP_JUMP_VIA_Z;
    run(r);
    chk({got.push_en, got.pc_val}, 13'h0ABC);
    chk(ncyc, 2);
    chk(status_flags, e);
    $display("test via_z done");
    for (int i = 0; i < 6; i++) begin
      sw_wr(CABE_FLAGS_ADDR, bfl[i]);
      r = '0;
      r.op = (i == 2 || i == 3) ? CABE_OP_JUMP_SIGNED : CABE_OP_JUMP_FLAG;
      r.bsel = bsl[i];
      r.want_set = (i == 0 || i == 3 || i == 4);
      r.pc = 12'h100;
      r.offs = 7'h7E;
      run(r);
      chk(ncyc, 2 - i[0]);
      if (!i[0]) begin
        chk(got.pc_val, 12'h0FF);
      end
      chk(status_flags, bfl[i]);
    end
    $display("test branch done");
    for (int i = 0; i < 5; i++) begin
      r = '0;
      r.op = sops[i];
      r.pc = 12'h200;
      r.d = 8'h04;
      r.r = i == 1 ? 8'h05 : 8'h04;
      r.io_val = 8'h04;
      r.bsel = 3'h2;
      r.want_set = (i == 2 || i == 4);
      r.next_two = (i != 2);
      run(r);
      chk(ncyc, cyc[i]);
      if (cyc[i] > 1) begin
        chk(got.pc_val, 12'h200 + cyc[i]);
      end
    end
    $display("test skip done");
    for (int i = 0; i < 3; i++) begin
      r = '0;
      r.op = i == 1 ? CABE_OP_IO_BIT_CLEAR : CABE_OP_IO_BIT_SET;
      r.io_addr = i == 2 ? 6'h20 : 6'h1F;
      r.io_val = 8'h81;
      r.bsel = i == 1 ? 3'h0 : 3'h1;
      run(r);
      chk(got.io_we, i != 2);
      if (i < 2) begin
        chk({got.io_addr, got.io_wdata}, i ? 14'h1F80 : 14'h1F83);
      end
      chk(ncyc, 2);
    end
    $display("test io_bit done");
    sw_wr(CABE_SP_HI_ADDR, 8'h05);
    sw_io_addr = CABE_SP_HI_ADDR;
    @(posedge clk_sys);
    #1 chk(sw_io_rdata, 8'h05);
    chk(stack_ptr[10:8], 3'h5);
    sw_io_addr = 6'h10;
    @(posedge clk_sys);
    #1 chk(sw_io_rdata, 0);
    $display("test sw_io done");
    print_verdict();
  end
endmodule
`default_nettype wire
